//--- hw/pin_input_filter.sv
// two-flop synchroniser with optional stable-level deglitch filter
`default_nettype none
module pin_input_filter
  import pmic_gpio_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = DEGLITCH_CYCLES
)
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic raw_in,
  input  wire logic filter_on,
  output var  logic level_q
);

  localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LAST_COUNT = CW'(FILTER_CYCLES - 1);

  logic          sync1_q;
  logic          sync2_q;
  logic [CW-1:0] count_q;

  // synchroniser, first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else if (ce)
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // level follows after the new value held for the full filter time
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      level_q <= 1'b0;
      count_q <= '0;
    end
    else if (ce)
    begin
      if (!filter_on)
      begin
        level_q <= sync2_q;
        count_q <= '0;
      end
      else if (sync2_q == level_q)
        count_q <= '0; // glitch shorter than the window is dropped
      else if (count_q == LAST_COUNT)
      begin
        level_q <= sync2_q;
        count_q <= '0;
      end
      else
        count_q <= count_q + CW'(1);
    end
  end

endmodule
`default_nettype wire

//--- hw/pmic_gpio_pin_config_port.sv
// pin 9/10 configuration, enable polarity, output and input level registers
// How it works
// - pin 9 function field in bits 7:5 picks gpio, data line, power good, sync clock, sleep or wake.
// - pin 10 function field in bits 7:5 picks gpio, main reset, processor reset, sleep or wake.
// - bit 4 adds an 8 us stable-level deglitch to an input pin, else it is only synchronised.
// - bit 3 enables the pull resistor and resets enabled.
// - bit 2 picks pull-up when set and pull-down when clear, only while the pull is enabled.
// - bit 1 picks open-drain when set and push-pull when clear, resetting to open-drain.
// - bit 0 makes the pin an output when set and an input when clear under the gpio function, resetting to input.
// - pin 9 and pin 10 configuration live at 0x39 and 0x3A, reset 0x0A, reloadable from nvm.
// - bit 5 of the enable configuration makes the enable input active low when set.
// - enable configuration at 0x3C resets to 0x88 and keeps its reserved bits as written.
// - register 0x3D holds the drive levels of pins 1 to 8, bit n-1 for pin n.
// - register 0x3E bit 0 drives pin 9 and bit 1 pin 10, bits 7:2 reserved.
// - register 0x3F is read-only input status resetting to 0x00.
// - bit n-1 of 0x3F reads the sampled level of pin n for pins 1 to 8.
`default_nettype none
module pmic_gpio_pin_config_port
  import pmic_gpio_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = DEGLITCH_CYCLES,
  parameter int unsigned LOW_PINS      = 8
)
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire reg_req_t            reg_req,
  output var  logic [7:0]          reg_rdata_q,
  output var  logic                reg_rvalid_q,
  input  wire logic                nvm_load,
  input  wire nvm_defaults_t       nvm_defaults,
  input  wire logic [LOW_PINS-1:0] low_pins_in,
  output var  logic [LOW_PINS-1:0] low_pins_drive_level_q,
  input  wire logic                pin9_pad_in,
  output var  pad_drive_t          pin9_pad_q,
  input  wire logic                pin10_pad_in,
  output var  pad_drive_t          pin10_pad_q,
  input  wire alt_drive_t          pin9_alt_in,
  input  wire alt_drive_t          pin10_alt_in,
  output var  logic                pin9_level_q,
  output var  logic                pin10_level_q,
  output var  logic [2:0]          pin9_function_select_q,
  output var  logic [2:0]          pin10_function_select_q,
  input  wire logic                enable_pin_in,
  output var  logic                enable_active_q
);

  pin_cfg_t            pin9_cfg_q;
  pin_cfg_t            pin10_cfg_q;
  logic [7:0]          enable_cfg_q;
  logic [7:0]          out_high_q;
  logic [LOW_PINS-1:0] low_levels;
  logic                enable_sync;
  logic [7:0]          rdata_d;
  pad_drive_t          pin9_pad_d;
  pad_drive_t          pin10_pad_d;
  logic                wr_en;

  assign wr_en = ce && reg_req.wr && !nvm_load;

  // pad controls from configuration, function owner and level
  function automatic pad_drive_t drive_of(input pin_cfg_t cfg, input logic gpio_lvl,
                                          input alt_drive_t alt, input logic alt_owns);
    pad_drive_t p;
    logic       lvl;
    logic       want;
    lvl  = (cfg.func == FUNC_GPIO) ? gpio_lvl : alt.level;
    want = (cfg.func == FUNC_GPIO) ? cfg.direction : (alt_owns && alt.oe);
    p.level     = cfg.drain_type ? 1'b0 : lvl;
    p.oe        = want && !(cfg.drain_type && lvl);
    p.pull_up   = cfg.pull_on && cfg.pull_direction;
    p.pull_down = cfg.pull_on && !cfg.pull_direction;
    return p;
  endfunction

  // pin 9 configuration register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      pin9_cfg_q <= pin_cfg_t'(PIN_CONFIG_RESET);
    else if (ce && nvm_load)
      pin9_cfg_q <= nvm_defaults.pin9;
    else if (wr_en && reg_req.addr == PIN9_CONFIG_ADDR)
      pin9_cfg_q <= pin_cfg_t'(reg_req.wdata);
  end

  // pin 10 configuration register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      pin10_cfg_q <= pin_cfg_t'(PIN_CONFIG_RESET);
    else if (ce && nvm_load)
      pin10_cfg_q <= nvm_defaults.pin10;
    else if (wr_en && reg_req.addr == PIN10_CONFIG_ADDR)
      pin10_cfg_q <= pin_cfg_t'(reg_req.wdata);
  end

  // enable pin configuration, reserved bits stored as written
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      enable_cfg_q <= ENABLE_PIN_CONFIG_RESET;
    else if (ce && nvm_load)
      enable_cfg_q <= nvm_defaults.enable_cfg;
    else if (wr_en && reg_req.addr == ENABLE_PIN_CONFIG_ADDR)
      enable_cfg_q <= reg_req.wdata;
  end

  // drive levels for pins 1 to 8
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      low_pins_drive_level_q <= LOW_PINS'(OUTPUT_LEVELS_RESET);
    else if (ce && nvm_load)
      low_pins_drive_level_q <= LOW_PINS'(nvm_defaults.out_low);
    else if (wr_en && reg_req.addr == OUTPUT_LEVELS_LOW_ADDR)
      low_pins_drive_level_q <= LOW_PINS'(reg_req.wdata);
  end

  // drive levels for pins 9 and 10, reserved bits dropped
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      out_high_q <= OUTPUT_LEVELS_RESET;
    else if (ce && nvm_load)
      out_high_q <= nvm_defaults.out_high & OUTPUT_HIGH_MASK;
    else if (wr_en && reg_req.addr == OUTPUT_LEVELS_HIGH_ADDR)
      out_high_q <= reg_req.wdata & OUTPUT_HIGH_MASK;
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rdata_d = UNMAPPED_READ_VALUE;
    unique case (reg_req.addr)
      PIN9_CONFIG_ADDR:        rdata_d = pin9_cfg_q;
      PIN10_CONFIG_ADDR:       rdata_d = pin10_cfg_q;
      ENABLE_PIN_CONFIG_ADDR:  rdata_d = enable_cfg_q;
      OUTPUT_LEVELS_LOW_ADDR:  rdata_d = 8'(low_pins_drive_level_q);
      OUTPUT_LEVELS_HIGH_ADDR: rdata_d = out_high_q;
      INPUT_LEVELS_LOW_ADDR:   rdata_d = 8'(low_levels);
      default:                 rdata_d = UNMAPPED_READ_VALUE;
    endcase
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      reg_rdata_q  <= UNMAPPED_READ_VALUE;
      reg_rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid_q <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata_q <= rdata_d;
    end
  end

  // input sampling for pins 1 to 8, synchronised only
  for (genvar i = 0; i < LOW_PINS; i++)
  begin : g_low_in
    pin_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .ce        (ce),
      .raw_in    (low_pins_in[i]),
      .filter_on (1'b0),
      .level_q   (low_levels[i])
    );
  end

  // pin 9 input path with deglitch while an input
  pin_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_pin9_filt (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .ce        (ce),
    .raw_in    (pin9_pad_in),
    .filter_on (pin9_cfg_q.filter_on && !pin9_cfg_q.direction),
    .level_q   (pin9_level_q)
  );

  // pin 10 input path with deglitch while an input
  pin_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_pin10_filt (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .ce        (ce),
    .raw_in    (pin10_pad_in),
    .filter_on (pin10_cfg_q.filter_on && !pin10_cfg_q.direction),
    .level_q   (pin10_level_q)
  );

  // enable input synchroniser
  pin_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_enable_sync (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .ce        (ce),
    .raw_in    (enable_pin_in),
    .filter_on (1'b0),
    .level_q   (enable_sync)
  );

  // enable asserted according to the polarity bit
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      enable_active_q <= 1'b0;
    else if (ce)
      enable_active_q <= enable_sync ^ enable_cfg_q[ENABLE_INPUT_POLARITY_BIT];
  end

  // pad control next values
  assign pin9_pad_d  = drive_of(pin9_cfg_q, out_high_q[PIN9_DRIVE_BIT], pin9_alt_in,
                                alt_drives(1'b0, pin9_cfg_q.func));
  assign pin10_pad_d = drive_of(pin10_cfg_q, out_high_q[PIN10_DRIVE_BIT], pin10_alt_in,
                                alt_drives(1'b1, pin10_cfg_q.func));

  // registered pad controls and function selects
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pin9_pad_q              <= '0;
      pin10_pad_q             <= '0;
      pin9_function_select_q  <= FUNC_GPIO;
      pin10_function_select_q <= FUNC_GPIO;
    end
    else if (ce)
    begin
      pin9_pad_q              <= pin9_pad_d;
      pin10_pad_q             <= pin10_pad_d;
      pin9_function_select_q  <= pin9_cfg_q.func;
      pin10_function_select_q <= pin10_cfg_q.func;
    end
  end

  // a read request answered next cycle
  sequence s_read_req(logic [7:0] a);
    ce && reg_req.rd && reg_req.addr == a;
  endsequence

  // a frozen-free follow-up cycle
  sequence s_next_ce;
    ce;
  endsequence

  chk_cfg9_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en && reg_req.addr == PIN9_CONFIG_ADDR |=> pin9_cfg_q == $past(reg_req.wdata))
    else $error("pin 9 config write lost");

  chk_cfg_reset: assert property (@(posedge core_clk)
    !nrst |=> pin9_cfg_q == PIN_CONFIG_RESET && pin10_cfg_q == PIN_CONFIG_RESET &&
              enable_cfg_q == ENABLE_PIN_CONFIG_RESET)
    else $error("config reset value wrong");

  chk_input_read: assert property (@(posedge core_clk) disable iff (!nrst)
    s_read_req(INPUT_LEVELS_LOW_ADDR) ##1 s_next_ce |-> reg_rvalid_q &&
      (reg_rdata_q == 8'($past(low_levels))))
    else $error("input level read wrong");

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    s_read_req(OUTPUT_LEVELS_HIGH_ADDR) |=> (reg_rdata_q & ~OUTPUT_HIGH_MASK) == 8'h00)
    else $error("reserved output bits not zero");

  chk_od_release: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin9_cfg_q.drain_type && pin9_pad_d.oe |=> pin9_pad_q.oe && !pin9_pad_q.level)
    else $error("open drain drove high");

  chk_od_high_off: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin9_cfg_q.func == FUNC_GPIO && pin9_cfg_q.drain_type &&
    out_high_q[PIN9_DRIVE_BIT] |=> !pin9_pad_q.oe)
    else $error("open drain not released");

  chk_input_no_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin10_cfg_q.func == FUNC_GPIO && !pin10_cfg_q.direction |=> !pin10_pad_q.oe)
    else $error("input pin driven");

  chk_alt_owns: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin9_cfg_q.func != FUNC_GPIO && !pin9_cfg_q.drain_type && pin9_alt_in.oe &&
    alt_drives(1'b0, pin9_cfg_q.func) |=> pin9_pad_q.oe &&
    pin9_pad_q.level == $past(pin9_alt_in.level))
    else $error("alternate function not driving");

  chk_pull_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    ce ##1 ce |-> (pin9_pad_q.pull_up || pin9_pad_q.pull_down) == $past(pin9_cfg_q.pull_on) &&
      !(pin9_pad_q.pull_up && pin9_pad_q.pull_down))
    else $error("pull control wrong");

  chk_enable_polarity: assert property (@(posedge core_clk) disable iff (!nrst)
    ce |=> enable_active_q ==
      ($past(enable_sync) ^ $past(enable_cfg_q[ENABLE_INPUT_POLARITY_BIT])))
    else $error("enable polarity wrong");

  chk_cfg10_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en && reg_req.addr == PIN10_CONFIG_ADDR |=> pin10_cfg_q == $past(reg_req.wdata))
    else $error("pin 10 config write lost");

  chk_enable_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en && reg_req.addr == ENABLE_PIN_CONFIG_ADDR |=> enable_cfg_q == $past(reg_req.wdata))
    else $error("enable config write lost");

  chk_low_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en && reg_req.addr == OUTPUT_LEVELS_LOW_ADDR |=>
      low_pins_drive_level_q == LOW_PINS'($past(reg_req.wdata)))
    else $error("low drive levels write lost");

  chk_high_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en && reg_req.addr == OUTPUT_LEVELS_HIGH_ADDR |=>
      out_high_q == ($past(reg_req.wdata) & OUTPUT_HIGH_MASK))
    else $error("high drive levels write lost");

  chk_nvm_load: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && nvm_load |=> pin9_cfg_q == $past(nvm_defaults.pin9) &&
      pin10_cfg_q == $past(nvm_defaults.pin10) &&
      enable_cfg_q == $past(nvm_defaults.enable_cfg))
    else $error("nvm defaults not loaded");

  chk_freeze_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !ce |=> $stable(pin9_cfg_q) && $stable(pin10_cfg_q) && $stable(enable_active_q))
    else $error("state moved with clock enable low");

  chk_read_answer: assert property (@(posedge core_clk) disable iff (!nrst)
    ce |=> reg_rvalid_q == $past(reg_req.rd))
    else $error("read answer strobe wrong");

  chk_fsel_copy: assert property (@(posedge core_clk) disable iff (!nrst)
    ce |=> pin9_function_select_q == $past(pin9_cfg_q.func) &&
      pin10_function_select_q == $past(pin10_cfg_q.func))
    else $error("function select copy wrong");

  chk_push_pull: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin10_cfg_q.func == FUNC_GPIO && pin10_cfg_q.direction &&
    !pin10_cfg_q.drain_type |=> pin10_pad_q.oe &&
    pin10_pad_q.level == $past(out_high_q[PIN10_DRIVE_BIT]))
    else $error("push pull pin 10 not driving its level");

  chk_alt_silent: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin10_cfg_q.func != FUNC_GPIO && !alt_drives(1'b1, pin10_cfg_q.func) |=>
      !pin10_pad_q.oe)
    else $error("input function drove pin 10");

  chk_od_pin10: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && pin10_cfg_q.drain_type |=> !pin10_pad_q.level)
    else $error("open drain pin 10 drove a high level");

endmodule
`default_nettype wire

//--- hw/unused_placeholder_never.sv
// empty
`default_nettype none
`default_nettype wire

//--- pkg/pmic_gpio_pkg.sv
// shared constants, field layouts and carrier types for the pin configuration port
`default_nettype none
package pmic_gpio_pkg;

  // register offsets
  localparam logic [7:0] PIN9_CONFIG_ADDR        = 8'h39;
  localparam logic [7:0] PIN10_CONFIG_ADDR       = 8'h3A;
  localparam logic [7:0] ENABLE_PIN_CONFIG_ADDR  = 8'h3C;
  localparam logic [7:0] OUTPUT_LEVELS_LOW_ADDR  = 8'h3D;
  localparam logic [7:0] OUTPUT_LEVELS_HIGH_ADDR = 8'h3E;
  localparam logic [7:0] INPUT_LEVELS_LOW_ADDR   = 8'h3F;

  // reset values
  localparam logic [7:0] PIN_CONFIG_RESET        = 8'h0A;
  localparam logic [7:0] ENABLE_PIN_CONFIG_RESET = 8'h88;
  localparam logic [7:0] OUTPUT_LEVELS_RESET     = 8'h00;
  localparam logic [7:0] INPUT_LEVELS_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE     = 8'h00;

  // field positions
  localparam int unsigned ENABLE_INPUT_POLARITY_BIT = 5;
  localparam int unsigned PIN9_DRIVE_BIT            = 0;
  localparam int unsigned PIN10_DRIVE_BIT           = 1;
  localparam logic [7:0]  OUTPUT_HIGH_MASK          = 8'h03;

  // function select codes
  localparam logic [2:0] FUNC_GPIO           = 3'h0;
  localparam logic [2:0] P9_FUNC_SPMI_DATA   = 3'h1;
  localparam logic [2:0] P9_FUNC_POWER_GOOD  = 3'h2;
  localparam logic [2:0] P9_FUNC_SYNC_CLOCK  = 3'h3;
  localparam logic [2:0] P10_FUNC_MAIN_RESET = 3'h1;
  localparam logic [2:0] P10_FUNC_PROC_RST_A = 3'h2;
  localparam logic [2:0] P10_FUNC_PROC_RST_B = 3'h3;
  localparam logic [2:0] FUNC_SLEEP_ONE      = 3'h4;
  localparam logic [2:0] FUNC_SLEEP_TWO      = 3'h5;
  localparam logic [2:0] FUNC_WAKE_ONE       = 3'h6;
  localparam logic [2:0] FUNC_WAKE_TWO       = 3'h7;

  // timing
  localparam int unsigned CLK_FREQ_MHZ     = 40;
  localparam int unsigned DEGLITCH_TIME_NS = 8000;
  localparam int unsigned DEGLITCH_CYCLES  = (DEGLITCH_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // per-pin configuration byte, msb first
  typedef struct packed {
    logic [2:0] func;
    logic       filter_on;
    logic       pull_on;
    logic       pull_direction;
    logic       drain_type;
    logic       direction;
  } pin_cfg_t;

  // pad controls for one two-way pin
  typedef struct packed {
    logic level;
    logic oe;
    logic pull_up;
    logic pull_down;
  } pad_drive_t;

  // drive request from an alternate function
  typedef struct packed {
    logic level;
    logic oe;
  } alt_drive_t;

  // register access request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  // defaults delivered by non-volatile memory
  typedef struct packed {
    pin_cfg_t   pin9;
    pin_cfg_t   pin10;
    logic [7:0] enable_cfg;
    logic [7:0] out_low;
    logic [7:0] out_high;
  } nvm_defaults_t;

  // true when the selected alternate function drives the pin
  function automatic logic alt_drives(input logic is_pin10, input logic [2:0] sel);
    if (is_pin10)
    begin
      return (sel == P10_FUNC_MAIN_RESET) || (sel == P10_FUNC_PROC_RST_A) ||
             (sel == P10_FUNC_PROC_RST_B);
    end
    return (sel == P9_FUNC_SPMI_DATA) || (sel == P9_FUNC_POWER_GOOD);
  endfunction

endpackage
`default_nettype wire

//--- verif/board_pins_model.sv
// board-side model of one configurable pad: device driver, external source and pulls
`default_nettype none
module board_pins_model
  import pmic_gpio_pkg::*;
(
  input  wire logic       core_clk,
  input  wire pad_drive_t pad_q,
  input  wire logic       ext_en,
  input  wire logic       ext_level,
  output var  logic       pad_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic float_q = 1'b0;

  // an undriven pad with no pull wanders every cycle instead of holding its last value
  always @(posedge core_clk)
    float_q <= ~pad_in;

  // wire level: device driver first, then the board source, then the selected pull
  always_comb
  begin
    if (pad_q.oe)
      pad_in = pad_q.level;
    else if (ext_en)
      pad_in = ext_level;
    else if (pad_q.pull_up)
      pad_in = 1'b1;
    else if (pad_q.pull_down)
      pad_in = 1'b0;
    else
      pad_in = float_q;
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the pin 9/10 configuration port
`default_nettype none
module tb_top
  import pmic_gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned FC = 4;
  logic          core_clk = 1'b0;
  logic          nrst;
  reg_req_t      reg_req;
  logic [7:0]    reg_rdata_q;
  logic          reg_rvalid_q;
  logic [7:0]    low_pins_in;
  logic [7:0]    low_pins_drive_level_q;
  logic          pin9_pad_in;
  logic          pin10_pad_in;
  pad_drive_t    pin9_pad_q;
  pad_drive_t    pin10_pad_q;
  alt_drive_t    pin9_alt_in;
  alt_drive_t    pin10_alt_in;
  logic          pin9_level_q;
  logic          pin10_level_q;
  logic [2:0]    fsel9;
  logic [2:0]    fsel10;
  logic          enable_pin_in;
  logic          enable_active_q;
  logic          ext_en;
  logic          ext_lvl;
  logic          ce;
  logic          nvm_load;
  nvm_defaults_t nvm_def;
  logic [7:0]    exp_q [$];
  int            failures = 0;
  int            checks = 0;
  logic [7:0]    ra [7] = '{8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
  logic [7:0]    rv [7] = '{8'h0A, 8'h0A, 8'h00, 8'h88, 8'h00, 8'h00, 8'h00};

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  pmic_gpio_pin_config_port #(.FILTER_CYCLES(FC)) dut (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .nvm_load(nvm_load),
    .nvm_defaults(nvm_def), .low_pins_in(low_pins_in),
    .low_pins_drive_level_q(low_pins_drive_level_q), .pin9_pad_in(pin9_pad_in),
    .pin9_pad_q(pin9_pad_q), .pin10_pad_in(pin10_pad_in), .pin10_pad_q(pin10_pad_q),
    .pin9_alt_in(pin9_alt_in), .pin10_alt_in(pin10_alt_in), .pin9_level_q(pin9_level_q),
    .pin10_level_q(pin10_level_q), .pin9_function_select_q(fsel9),
    .pin10_function_select_q(fsel10), .enable_pin_in(enable_pin_in),
    .enable_active_q(enable_active_q));

  board_pins_model pad9 (.core_clk(core_clk), .pad_q(pin9_pad_q), .ext_en(ext_en),
    .ext_level(ext_lvl), .pad_in(pin9_pad_in));
  board_pins_model pad10 (.core_clk(core_clk), .pad_q(pin10_pad_q), .ext_en(1'b0),
    .ext_level(1'b0), .pad_in(pin10_pad_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one-cycle write strobe, launched and dropped on falling edges
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge core_clk);
    reg_req.wr = 1'b0;
  endtask

  // one-cycle read strobe; the expected byte waits in the queue
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    exp_q.push_back(e);
    @(negedge core_clk);
    reg_req.rd = 1'b0;
  endtask

  // bounded wait until every pending read has answered
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    if (exp_q.size() > 0)
    begin
      failures++;
      tally_and_finish();
    end
  endtask

  // read watcher: each answer is matched against the oldest note
  always @(negedge core_clk)
    if (nrst === 1'b1 && reg_rvalid_q === 1'b1)
      check(reg_rdata_q, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);

  initial
  begin
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] w3;
    logic       a;
    logic       d9;
    logic       d10;
    pad_drive_t x;
    nrst = 1'b0;
    reg_req = '0;
    low_pins_in = 8'h00;
    pin9_alt_in = '0;
    pin10_alt_in = '0;
    enable_pin_in = 1'b0;
    ext_en = 1'b0;
    ext_lvl = 1'b0;
    ce = 1'b1;
    nvm_load = 1'b0;
    nvm_def = '0;
    void'($urandom(32'h0B73));
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    // reset values, an unmapped hole included
    foreach (ra[k])
      reg_rd(ra[k], rv[k]);
    drain();
    $display("test reset values done");
    // random byte everywhere but 0x3C, which takes only its polarity bit: reserved bits, status and hole must not keep it
    d = 8'($urandom);
    w3 = (d & 8'h20) | ENABLE_PIN_CONFIG_RESET;
    foreach (ra[k])
      reg_wr(ra[k], k == 3 ? w3 : d);
    check(low_pins_drive_level_q, d);
    foreach (ra[k])
      reg_rd(ra[k], (k == 2 || k == 6) ? 8'h00 : (k == 5 ? d & 8'h03 : (k == 3 ? w3 : d)));
    drain();
    $display("test write readback done");
    // every driver and pull combination for both pads
    for (int i = 0; i < 32; i++)
    begin
      e = 8'(i);
      reg_wr(OUTPUT_LEVELS_HIGH_ADDR, {6'h00, e[4], e[4]});
      reg_wr(PIN9_CONFIG_ADDR, {4'h0, e[3:0]});
      reg_wr(PIN10_CONFIG_ADDR, {4'h0, e[3:0]});
      repeat (4) @(negedge core_clk);
      x = '{level: !e[1] & e[4], oe: e[0] & !(e[1] & e[4]), pull_up: e[3] & e[2],
            pull_down: e[3] & !e[2]};
      check(pin9_pad_q, x);
      check(pin10_pad_q, x);
      if (x.oe || e[3])
        check(pin10_level_q, x.oe ? x.level : e[2]);
    end
    $display("test pad drive done");
    // every function code; only output-type functions take the pad
    reg_wr(OUTPUT_LEVELS_HIGH_ADDR, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      a = 1'($urandom);
      pin9_alt_in = '{level: a, oe: 1'b1};
      pin10_alt_in = '{level: a, oe: 1'b1};
      reg_wr(PIN9_CONFIG_ADDR, {3'(c), 5'h01});
      reg_wr(PIN10_CONFIG_ADDR, {3'(c), 5'h01});
      repeat (3) @(negedge core_clk);
      d9 = (c == 1 || c == 2);
      d10 = (c >= 1 && c <= 3);
      check(fsel9, 8'(c));
      check(fsel10, 8'(c));
      check(pin9_pad_q.oe, d9 || c == 0);
      check(pin10_pad_q.oe, d10 || c == 0);
      if (d9 || c == 0)
        check(pin9_pad_q.level, d9 & a);
      if (d10 || c == 0)
        check(pin10_pad_q.level, d10 & a);
    end
    $display("test functions done");
    // input sampling: low pins, then pin 9 plain and deglitched
    low_pins_in = 8'($urandom);
    repeat (4) @(negedge core_clk);
    reg_rd(INPUT_LEVELS_LOW_ADDR, low_pins_in);
    drain();
    reg_wr(PIN9_CONFIG_ADDR, 8'h00);
    ext_en = 1'b1;
    repeat (4) @(negedge core_clk);
    ext_lvl = 1'b1;
    repeat (2) @(negedge core_clk);
    check(pin9_level_q, 1'b0);
    @(negedge core_clk);
    check(pin9_level_q, 1'b1);
    ext_lvl = 1'b0;
    reg_wr(PIN9_CONFIG_ADDR, 8'h10);
    repeat (12) @(negedge core_clk);
    ext_lvl = 1'b1;
    repeat (2) @(negedge core_clk);
    ext_lvl = 1'b0;
    repeat (12) @(negedge core_clk);
    check(pin9_level_q, 1'b0);
    ext_lvl = 1'b1;
    repeat (12) @(negedge core_clk);
    check(pin9_level_q, 1'b1);
    $display("test input levels done");
    // enable polarity both ways, reserved bits kept
    reg_wr(ENABLE_PIN_CONFIG_ADDR, 8'h88);
    enable_pin_in = 1'b1;
    repeat (5) @(negedge core_clk);
    check(enable_active_q, 1'b1);
    reg_wr(ENABLE_PIN_CONFIG_ADDR, 8'hA8);
    repeat (5) @(negedge core_clk);
    check(enable_active_q, 1'b0);
    enable_pin_in = 1'b0;
    repeat (5) @(negedge core_clk);
    check(enable_active_q, 1'b1);
    reg_rd(ENABLE_PIN_CONFIG_ADDR, 8'hA8);
    drain();
    $display("test enable polarity done");
    // nvm reload waits for clock enable, then a mid-run reset restores every default
    nvm_def = '{pin9: pin_cfg_t'(8'($urandom)), pin10: pin_cfg_t'(8'($urandom)),
                enable_cfg: w3, out_low: 8'($urandom), out_high: d};
    ce = 1'b0;
    nvm_load = 1'b1;
    repeat (2) @(negedge core_clk);
    ce = 1'b1;
    nvm_load = 1'b0;
    reg_rd(PIN9_CONFIG_ADDR, 8'h10);
    nvm_load = 1'b1;
    @(negedge core_clk);
    nvm_load = 1'b0;
    reg_rd(PIN9_CONFIG_ADDR, nvm_def.pin9);
    reg_rd(PIN10_CONFIG_ADDR, nvm_def.pin10);
    reg_rd(ENABLE_PIN_CONFIG_ADDR, w3);
    reg_rd(OUTPUT_LEVELS_HIGH_ADDR, d & OUTPUT_HIGH_MASK);
    check(low_pins_drive_level_q, nvm_def.out_low);
    drain();
    nrst = 1'b0;
    @(negedge core_clk);
    nrst = 1'b1;
    foreach (ra[k])
      reg_rd(ra[k], k == 6 ? low_pins_in : rv[k]);
    drain();
    $display("test reload and reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
